// ===== cache_parity_test_control.sv
// parity enable, parity override and cache test routing for cache maintenance operations
//
// What this block does
// [R1] parity_enable turns parity on for both caches and scratchpads; resets to zero.
// [R2] parity_enable writable only if parity built in; otherwise always reads zero.
// [R3] enabled and no override: store-tag and store-data write computed parity.
// [R4] override: tag parity from tag_low bit, data parity from parity bit fields.
// [R5] parity_override affects only store-tag and store-data operations.
// [R6] way_select_test sends load-tag/store-tag to way-select RAM, tag RAM untouched.
// [R7] way test uses low six physical_tag_field bits as source and destination.
// [R8] way_select_test enables store-data, writing data_low to the addressed word.
// [R9] scratchpad_route sends load-tag, store-tag, store-data to the scratchpad port.
// [R10] instruction cache load-tag loads icache_parity_bits from data array parity.
// [R11] data cache load-tag loads dcache_parity_bits with per-byte parity.
// [R12] parity disabled or absent: load-tag zeroes the parity bit field of the cache it reads; the other field keeps its value.
// [R13] reserved bits 27:8 are written zero and always read zero.
// [R14] a control write applies from the next operation; load-tag parity capture uses parity_enable as it stands when the response arrives.
`timescale 1ns/100ps
`default_nettype none
module cache_parity_test_control #(
  parameter bit PARITY_PRESENT = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ctrl_wr_en,
  input wire logic [31:0] ctrl_wr_data,
  output logic [31:0] ctrl_rd_data_q,
  input wire logic op_valid,
  input wire cache_parity_test_pkg::cache_op_t op_kind,
  input wire logic op_icache,
  input wire logic [31:0] op_addr,
  input wire logic [31:0] tag_low_in,
  input wire logic [31:0] data_low_in,
  input wire logic resp_valid,
  input wire logic resp_icache,
  input wire logic resp_way,
  input wire logic [5:0] resp_way_bits,
  input wire logic [3:0] resp_parity,
  output logic tag_re_q,
  output logic tag_we_q,
  output logic way_re_q,
  output logic way_we_q,
  output logic data_we_q,
  output logic scratch_re_q,
  output logic scratch_we_q,
  output logic op_icache_q,
  output logic [31:0] addr_q,
  output logic [31:0] wdata_q,
  output logic [5:0] way_wdata_q,
  output logic parity_we_q,
  output logic tag_parity_q,
  output logic [3:0] data_parity_q,
  output logic tag_low_way_we_q,
  output logic [5:0] tag_low_way_q
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [3:0] byte_parity(input logic [31:0] w);
    byte_parity = {^w[31:24], ^w[23:16], ^w[15:8], ^w[7:0]};
  endfunction : byte_parity

  logic parity_en;
  logic par_ovr;
  logic way_test;
  logic scratch_route;
  logic is_lt;
  logic is_st;
  logic is_sd;
  assign parity_en = ctrl_rd_data_q[cache_parity_test_pkg::PARITY_EN_BIT];
  assign par_ovr = ctrl_rd_data_q[cache_parity_test_pkg::OVERRIDE_BIT];
  assign way_test = ctrl_rd_data_q[cache_parity_test_pkg::WAY_TEST_BIT];
  assign scratch_route = ctrl_rd_data_q[cache_parity_test_pkg::SCRATCH_ROUTE_BIT];
  assign is_lt = op_valid && (op_kind == cache_parity_test_pkg::OP_LOAD_TAG);
  assign is_st = op_valid && (op_kind == cache_parity_test_pkg::OP_STORE_TAG);
  assign is_sd = op_valid && (op_kind == cache_parity_test_pkg::OP_STORE_DATA);

  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic [31:0] ctrl_d;
  always_comb
  begin
    ctrl_d = ctrl_rd_data_q;
    if (ctrl_wr_en)
    begin
      // [R13] reserved forced zero
      ctrl_d = ctrl_wr_data & cache_parity_test_pkg::CTRL_WMASK;
      // [R2] gated by build option
      if (!PARITY_PRESENT)
        ctrl_d[cache_parity_test_pkg::PARITY_EN_BIT] = 1'b0;
    end
    // load-tag capture wins over a same-cycle software write
    if (resp_valid && !resp_way)
    begin
      // [R12] zero when parity off
      if (resp_icache)
        // [R10] instruction parity capture
        ctrl_d[cache_parity_test_pkg::IPAR_MSB:cache_parity_test_pkg::IPAR_LSB] =
          (parity_en && PARITY_PRESENT) ? resp_parity : 4'h0;
      else
        // [R11] data byte parity capture
        ctrl_d[cache_parity_test_pkg::DPAR_MSB:cache_parity_test_pkg::DPAR_LSB] =
          (parity_en && PARITY_PRESENT) ? resp_parity : 4'h0;
    end
  end

  // [R1] parity off after reset
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_rd_data_q <= cache_parity_test_pkg::CTRL_RESET;
    else
      ctrl_rd_data_q <= ctrl_d;
  end

  // ----------------------------------------
  // operation routing
  // ----------------------------------------
  // routing samples the register before any write in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tag_re_q <= 1'b0;
      tag_we_q <= 1'b0;
      way_re_q <= 1'b0;
      way_we_q <= 1'b0;
      data_we_q <= 1'b0;
      scratch_re_q <= 1'b0;
      scratch_we_q <= 1'b0;
    end
    else
    begin
      // [R14] old value steers this op
      // [R9] scratchpad takes priority
      scratch_re_q <= scratch_route && is_lt;
      scratch_we_q <= scratch_route && (is_st || is_sd);
      // [R6] way RAM instead of tag
      way_re_q <= !scratch_route && way_test && is_lt;
      way_we_q <= !scratch_route && way_test && is_st;
      tag_re_q <= !scratch_route && !way_test && is_lt;
      tag_we_q <= !scratch_route && !way_test && is_st;
      // [R8] store data needs test mode
      data_we_q <= !scratch_route && way_test && is_sd;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_icache_q <= 1'b0;
      addr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      way_wdata_q <= 6'h00;
    end
    else if (op_valid)
    begin
      op_icache_q <= op_icache;
      addr_q <= op_addr;
      wdata_q <= is_sd ? data_low_in : tag_low_in;
      // [R7] low six physical tag bits
      way_wdata_q <= tag_low_in[cache_parity_test_pkg::TAG_PHYS_LSB +: cache_parity_test_pkg::WAY_BITS];
    end
  end

  // ----------------------------------------
  // parity generation
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      parity_we_q <= 1'b0;
      tag_parity_q <= 1'b0;
      data_parity_q <= 4'h0;
    end
    else
    begin
      // [R5] only store-tag and store-data
      parity_we_q <= parity_en && (is_st || is_sd);
      if (is_st || is_sd)
      begin
        // [R4] override source select
        if (par_ovr)
        begin
          tag_parity_q <= tag_low_in[cache_parity_test_pkg::TAG_P_BIT];
          data_parity_q <= op_icache ?
            ctrl_rd_data_q[cache_parity_test_pkg::IPAR_MSB:cache_parity_test_pkg::IPAR_LSB] :
            ctrl_rd_data_q[cache_parity_test_pkg::DPAR_MSB:cache_parity_test_pkg::DPAR_LSB];
        end
        else
        begin
          // [R3] internally computed parity
          tag_parity_q <= ^tag_low_in[31:cache_parity_test_pkg::TAG_PHYS_LSB];
          data_parity_q <= byte_parity(data_low_in);
        end
      end
    end
  end

  // ----------------------------------------
  // way-select read back
  // ----------------------------------------
  // [R7] way bits return to tag low
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tag_low_way_we_q <= 1'b0;
      tag_low_way_q <= 6'h00;
    end
    else
    begin
      tag_low_way_we_q <= resp_valid && resp_way;
      if (resp_valid && resp_way)
        tag_low_way_q <= resp_way_bits;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_par_en_reset;
    @(posedge clk_sys) $rose(rst_n) |-> !parity_en;
  endproperty
  a_par_en_reset: assert property (p_par_en_reset) else $error("parity enable not clear after reset"); // [R1]
  property p_par_en_absent;
    @(posedge clk_sys) disable iff (!rst_n) !PARITY_PRESENT |-> !parity_en;
  endproperty
  a_par_en_absent: assert property (p_par_en_absent) else $error("parity enable set without option"); // [R2]
  property p_calc_parity;
    @(posedge clk_sys) disable iff (!rst_n)
      (is_sd && parity_en && !par_ovr) |=> (parity_we_q && data_parity_q == byte_parity($past(data_low_in)));
  endproperty
  a_calc_parity: assert property (p_calc_parity) else $error("computed data parity wrong"); // [R3]
  property p_override_tag;
    @(posedge clk_sys) disable iff (!rst_n)
      (is_st && parity_en && par_ovr) |=> tag_parity_q == $past(tag_low_in[cache_parity_test_pkg::TAG_P_BIT]);
  endproperty
  a_override_tag: assert property (p_override_tag) else $error("override tag parity wrong"); // [R4]
  property p_parity_scope;
    @(posedge clk_sys) disable iff (!rst_n) !(is_st || is_sd) |=> !parity_we_q;
  endproperty
  a_parity_scope: assert property (p_parity_scope) else $error("parity written on other op"); // [R5]
  property p_way_test;
    @(posedge clk_sys) disable iff (!rst_n) (is_st && way_test && !scratch_route) |=> (way_we_q && !tag_we_q);
  endproperty
  a_way_test: assert property (p_way_test) else $error("way test touched tag RAM"); // [R6]
  property p_way_src;
    @(posedge clk_sys) disable iff (!rst_n)
      way_we_q |-> way_wdata_q == $past(tag_low_in[15:10]);
  endproperty
  a_way_src: assert property (p_way_src) else $error("way write source wrong"); // [R7]
  property p_store_data_gate;
    @(posedge clk_sys) disable iff (!rst_n) data_we_q |-> ($past(way_test) && wdata_q == $past(data_low_in));
  endproperty
  a_store_data_gate: assert property (p_store_data_gate) else $error("store data without test mode"); // [R8]
  property p_scratch_route;
    @(posedge clk_sys) disable iff (!rst_n)
      (scratch_route && (is_st || is_sd)) |=> (scratch_we_q && !tag_we_q && !data_we_q && !way_we_q);
  endproperty
  a_scratch_route: assert property (p_scratch_route) else $error("scratchpad route missed"); // [R9]
  property p_ipar_load;
    @(posedge clk_sys) disable iff (!rst_n)
      (resp_valid && !resp_way && resp_icache && parity_en) |=> ctrl_rd_data_q[7:4] == $past(resp_parity);
  endproperty
  a_ipar_load: assert property (p_ipar_load) else $error("instruction parity not captured"); // [R10]
  property p_dpar_load;
    @(posedge clk_sys) disable iff (!rst_n)
      (resp_valid && !resp_way && !resp_icache && parity_en) |=> ctrl_rd_data_q[3:0] == $past(resp_parity);
  endproperty
  a_dpar_load: assert property (p_dpar_load) else $error("data parity not captured"); // [R11]
  property p_par_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      (resp_valid && !resp_way && !parity_en) |=> (ctrl_rd_data_q[7:4] == 4'h0 || !$past(resp_icache))
        && (ctrl_rd_data_q[3:0] == 4'h0 || $past(resp_icache));
  endproperty
  a_par_zero: assert property (p_par_zero) else $error("parity bits not zero when disabled"); // [R12]
  property p_reserved;
    @(posedge clk_sys) disable iff (!rst_n) ctrl_rd_data_q[27:8] == 20'h00000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero"); // [R13]
  property p_old_ctrl;
    @(posedge clk_sys) disable iff (!rst_n)
      (is_st && ctrl_wr_en && !scratch_route && !way_test) |=> tag_we_q;
  endproperty
  a_old_ctrl: assert property (p_old_ctrl) else $error("write applied to op in flight"); // [R14]

  c_way_store: cover property (@(posedge clk_sys) disable iff (!rst_n) way_we_q);
  c_scratch_read: cover property (@(posedge clk_sys) disable iff (!rst_n) scratch_re_q);
  c_override: cover property (@(posedge clk_sys) disable iff (!rst_n) is_sd && parity_en && par_ovr);
  c_capture: cover property (@(posedge clk_sys) disable iff (!rst_n) resp_valid && parity_en && !resp_way);

endmodule : cache_parity_test_control
`default_nettype wire

// ===== cache_parity_test_pkg.sv
// constants and types for the cache parity and test control block
package cache_parity_test_pkg;
  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int PARITY_EN_BIT = 31;
  localparam int OVERRIDE_BIT = 30;
  localparam int WAY_TEST_BIT = 29;
  localparam int SCRATCH_ROUTE_BIT = 28;
  localparam int RSV_MSB = 27;
  localparam int RSV_LSB = 8;
  localparam int IPAR_MSB = 7;
  localparam int IPAR_LSB = 4;
  localparam int DPAR_MSB = 3;
  localparam int DPAR_LSB = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'hF000_00FF;
  // ----------------------------------------
  // tag low register layout
  // ----------------------------------------
  localparam int TAG_P_BIT = 6;
  localparam int TAG_PHYS_LSB = 10;
  localparam int WAY_BITS = 6;
  // ----------------------------------------
  // cache operation kinds
  // ----------------------------------------
  typedef enum logic [1:0] {
    OP_OTHER,
    OP_LOAD_TAG,
    OP_STORE_TAG,
    OP_STORE_DATA
  } cache_op_t;
endpackage : cache_parity_test_pkg

// ===== cache_array_model.sv
// behavioural cache and way-select array model answering load-tag reads
`timescale 1ns/100ps
`default_nettype none
module cache_array_model #(
  parameter logic [3:0] PAR_I = 4'hA,
  parameter logic [3:0] PAR_D = 4'h5,
  parameter logic [5:0] WAY_PAT = 6'h2D
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic tag_re_q,
  input wire logic way_re_q,
  input wire logic op_icache_q,
  output logic resp_valid,
  output logic resp_icache,
  output logic resp_way,
  output logic [5:0] resp_way_bits,
  output logic [3:0] resp_parity
);
  // ----------------------------------------
  // read port
  // ----------------------------------------
  // idle way-bit and parity lines flip each cycle so stale data never passes as a fresh answer
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resp_valid <= 1'b0;
      resp_icache <= 1'b0;
      resp_way <= 1'b0;
      resp_way_bits <= 6'h00;
      resp_parity <= 4'h0;
    end
    else if (tag_re_q || way_re_q)
    begin
      resp_valid <= 1'b1;
      resp_icache <= op_icache_q;
      resp_way <= way_re_q;
      resp_way_bits <= WAY_PAT;
      resp_parity <= op_icache_q ? PAR_I : PAR_D;
    end
    else
    begin
      resp_valid <= 1'b0;
      resp_way_bits <= ~resp_way_bits;
      resp_parity <= ~resp_parity;
    end
  end
endmodule : cache_array_model
`default_nettype wire

// ===== tb_top.sv
// self-checking testbench for the cache parity and test control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // ----------------------------------------
  // stimulus and wiring
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ctrl_wr_en = 1'b0;
  logic [31:0] ctrl_wr_data = 32'h0000_0000;
  logic op_valid = 1'b0;
  cache_parity_test_pkg::cache_op_t op_kind = cache_parity_test_pkg::OP_OTHER;
  logic op_icache = 1'b0;
  logic [31:0] op_addr = 32'h0000_1234;
  logic [31:0] tag_low_in = 32'h0000_3400;
  logic [31:0] data_low_in = 32'hCAFE_0123;
  logic [31:0] ctrl, ctrl_np, addr_q, wdata_q;
  logic rv, ri, rw, tag_re_q, tag_we_q, way_re_q, way_we_q, data_we_q, scratch_re_q, scratch_we_q;
  logic op_icache_q, parity_we_q, tag_parity_q, way_rb_we;
  logic [5:0] rwb, way_wdata_q, way_rb;
  logic [3:0] rp, data_parity_q;
  logic [6:0] stb;
  int miscompares = 0;
  int samples_checked = 0;
  assign stb = {tag_re_q, tag_we_q, way_re_q, way_we_q, data_we_q, scratch_re_q, scratch_we_q};
  always #4 clk_sys = ~clk_sys;
  cache_parity_test_control #(.PARITY_PRESENT(1'b1)) cache_parity_test_control_inst (.clk_sys(clk_sys),
    .rst_n(rst_n), .ctrl_wr_en(ctrl_wr_en), .ctrl_wr_data(ctrl_wr_data), .ctrl_rd_data_q(ctrl),
    .op_valid(op_valid), .op_kind(op_kind), .op_icache(op_icache), .op_addr(op_addr),
    .tag_low_in(tag_low_in), .data_low_in(data_low_in), .resp_valid(rv), .resp_icache(ri),
    .resp_way(rw), .resp_way_bits(rwb), .resp_parity(rp), .tag_re_q(tag_re_q), .tag_we_q(tag_we_q),
    .way_re_q(way_re_q), .way_we_q(way_we_q), .data_we_q(data_we_q), .scratch_re_q(scratch_re_q),
    .scratch_we_q(scratch_we_q), .op_icache_q(op_icache_q), .addr_q(addr_q), .wdata_q(wdata_q),
    .way_wdata_q(way_wdata_q), .parity_we_q(parity_we_q), .tag_parity_q(tag_parity_q),
    .data_parity_q(data_parity_q), .tag_low_way_we_q(way_rb_we), .tag_low_way_q(way_rb));
  cache_array_model #(.PAR_I(4'hA), .PAR_D(4'h5), .WAY_PAT(6'h2D)) cache_array_model_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .tag_re_q(tag_re_q), .way_re_q(way_re_q),
    .op_icache_q(op_icache_q), .resp_valid(rv), .resp_icache(ri), .resp_way(rw),
    .resp_way_bits(rwb), .resp_parity(rp));
  // second copy built without the parity option
  if (1)
  begin : no_parity
    cache_parity_test_control #(.PARITY_PRESENT(1'b0)) cache_parity_test_control_inst (.clk_sys(clk_sys),
      .rst_n(rst_n), .ctrl_wr_en(ctrl_wr_en), .ctrl_wr_data(ctrl_wr_data), .ctrl_rd_data_q(ctrl_np),
      .op_valid(op_valid), .op_kind(op_kind), .op_icache(op_icache), .op_addr(op_addr),
      .tag_low_in(tag_low_in), .data_low_in(data_low_in), .resp_valid(rv), .resp_icache(ri),
      .resp_way(rw), .resp_way_bits(rwb), .resp_parity(rp), .tag_re_q(), .tag_we_q(), .way_re_q(),
      .way_we_q(), .data_we_q(), .scratch_re_q(), .scratch_we_q(), .op_icache_q(), .addr_q(), .wdata_q(),
      .way_wdata_q(), .parity_we_q(), .tag_parity_q(), .data_parity_q(), .tag_low_way_we_q(),
      .tag_low_way_q());
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [31:0] d);
    @(negedge clk_sys);
    ctrl_wr_en = 1'b1;
    ctrl_wr_data = d;
    @(negedge clk_sys);
    ctrl_wr_en = 1'b0;
  endtask : wr
  // strobes are looked at in the single cycle they stand
  task automatic op(input cache_parity_test_pkg::cache_op_t k, input logic ic, input logic [6:0] e);
    @(negedge clk_sys);
    op_valid = 1'b1;
    op_kind = k;
    op_icache = ic;
    @(negedge clk_sys);
    op_valid = 1'b0;
    chk("strobes", {25'h0000000, e}, {25'h0000000, stb});
  endtask : op
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    #16000;
    miscompares++;
    summarize();
  end
  initial
  begin
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    chk("ctrl", 32'h0000_0000, ctrl);
    wr(32'hF000_00FF);
    chk("ctrl", 32'hF000_00FF, ctrl);
    chk("ctrl_np", 32'h7000_00FF, ctrl_np);
    $display("test register done");
    wr(32'h8000_0000);
    op(cache_parity_test_pkg::OP_STORE_TAG, 1'b0, 7'h20);
    chk("parity_we", 32'h0000_0001, {31'h0, parity_we_q});
    chk("tag_parity", {31'h0, ^tag_low_in[31:10]}, {31'h0, tag_parity_q});
    chk("addr", op_addr, addr_q);
    op(cache_parity_test_pkg::OP_STORE_DATA, 1'b0, 7'h00);
    chk("data_parity", 32'h0000_0007, {28'h0, data_parity_q});
    wr(32'hC000_0096);
    op(cache_parity_test_pkg::OP_STORE_TAG, 1'b0, 7'h20);
    chk("tag_parity", {31'h0, tag_low_in[6]}, {31'h0, tag_parity_q});
    op(cache_parity_test_pkg::OP_OTHER, 1'b0, 7'h00);
    chk("parity_we", 32'h0000_0000, {31'h0, parity_we_q});
    op(cache_parity_test_pkg::OP_STORE_DATA, 1'b0, 7'h00);
    $display("test parity done");
    wr(32'hE000_0096);
    op(cache_parity_test_pkg::OP_STORE_TAG, 1'b1, 7'h08);
    chk("op_icache", 32'h0000_0001, {31'h0, op_icache_q});
    chk("way_wdata", {26'h0, tag_low_in[15:10]}, {26'h0, way_wdata_q});
    op(cache_parity_test_pkg::OP_STORE_DATA, 1'b1, 7'h04);
    chk("wdata", data_low_in, wdata_q);
    chk("data_parity", 32'h0000_0009, {28'h0, data_parity_q});
    op(cache_parity_test_pkg::OP_LOAD_TAG, 1'b1, 7'h10);
    repeat (2) @(negedge clk_sys);
    chk("way_rb_we", 32'h0000_0001, {31'h0, way_rb_we});
    chk("way_rb", 32'h0000_002D, {26'h0, way_rb});
    chk("ctrl", 32'hE000_0096, ctrl);
    $display("test way select done");
    wr(32'h8000_0000);
    op(cache_parity_test_pkg::OP_LOAD_TAG, 1'b1, 7'h40);
    repeat (2) @(negedge clk_sys);
    chk("ctrl", 32'h8000_00A0, ctrl);
    op(cache_parity_test_pkg::OP_LOAD_TAG, 1'b0, 7'h40);
    repeat (2) @(negedge clk_sys);
    chk("ctrl", 32'h8000_00A5, ctrl);
    chk("ctrl_np", 32'h0000_0000, ctrl_np);
    wr(32'h0000_00FF);
    op(cache_parity_test_pkg::OP_LOAD_TAG, 1'b0, 7'h40);
    repeat (2) @(negedge clk_sys);
    chk("ctrl", 32'h0000_00F0, ctrl);
    $display("test load tag done");
    wr(32'h3000_0000);
    op(cache_parity_test_pkg::OP_LOAD_TAG, 1'b0, 7'h02);
    op(cache_parity_test_pkg::OP_STORE_TAG, 1'b0, 7'h01);
    op(cache_parity_test_pkg::OP_STORE_DATA, 1'b0, 7'h01);
    wr(32'h8000_0000);
    @(negedge clk_sys);
    ctrl_wr_en = 1'b1;
    ctrl_wr_data = 32'h2000_0000;
    op_valid = 1'b1;
    op_kind = cache_parity_test_pkg::OP_STORE_TAG;
    @(negedge clk_sys);
    ctrl_wr_en = 1'b0;
    op_valid = 1'b0;
    chk("strobes", 32'h0000_0020, {25'h0000000, stb});
    op(cache_parity_test_pkg::OP_STORE_TAG, 1'b0, 7'h08);
    $display("test scratchpad and ordering done");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
